// File: bench/scpc_comparator_model.sv
// Behavioural source of phase comparator samples for the lock detector.
`timescale 1ns/10ps
// ==========================================================================
// Comparator sample model
module scpc_comparator_model (
  input  wire logic        clock,
  input  wire logic        startRun,
  input  wire logic [11:0] runLength,
  output logic             phaseAligned
);
  logic [11:0] left_reg = 12'h000;
  // One sample each clock: aligned while a run lasts, misaligned after it.
  always @(posedge clock) begin
    if (startRun) left_reg <= runLength;
    else if (left_reg != 12'h000) left_reg <= left_reg - 12'h001;
  end
  // Outside a run the samples are misaligned, so no lock is ever given free.
  assign phaseAligned = (left_reg != 12'h000);
endmodule

// File: bench/scpc_control_bench.sv
// Self-checking bench for the system clock multiplier control block.
`timescale 1ns/10ps
`include "scpc_map.svh"
// ==========================================================================
// Bench top
module scpc_control_bench;
  logic        clock = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, startRun = 1'b0, phaseAligned, pready, pslverr;
  logic [11:0] paddr = 12'h000, runLength = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        directPathSel, multiplierEnable, crystalAmpEnable, irq;
  logic        doublerEnable, externalFilter, multiplierLocked, clockStable;
  logic [3:0]  predivideRatio;
  logic [7:0]  feedbackDivide;
  logic [2:0]  pumpCurrent;
  int          fails = 0, totalChecks = 0, seed = 84020, n;
  int          pathSet[4] = '{32, 1, 2, 3};
  int          pathExp[4] = '{4, 2, 3, 3};
  scpc_control u_scpc_control (.clock, .resetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .phaseAligned,
    .directPathSel, .multiplierEnable, .crystalAmpEnable, .doublerEnable,
    .predivideRatio, .feedbackDivide, .pumpCurrent, .externalFilter,
    .multiplierLocked, .clockStable, .irq);
  scpc_comparator_model u_scpc_comparator_model (.clock, .startRun,
    .runLength, .phaseAligned);
  // Clock of 4 ns period.
  always #2 clock = ~clock;
  // Expected automatic pump step and lock threshold.
  function automatic int autoPump(input int fb);
    return (fb >> 5) & 7;
  endfunction
  function automatic int lockCount(input int code);
    return 128 << code;
  endfunction
  // Compares one value and counts it.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reportAndStop;
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One APB transfer; read data and error are taken at the access edge.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic err);
    int k;
    k = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      fails++;
      reportAndStop;
    end
    check(32'(pslverr), 32'(err));
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input int d);
    apb(1'b1, a, d, 1'b0);
  endtask
  task automatic rdchk(input logic [11:0] a, input int e);
    apb(1'b0, a, 32'h0, 1'b0);
    check(rd, e);
  endtask
  // Starts an aligned run of len samples, then waits wt cycles.
  task automatic runFor(input int len, input int wt);
    @(posedge clock);
    startRun <= 1'b1;
    runLength <= 12'(len);
    @(posedge clock);
    startRun <= 1'b0;
    repeat (wt) @(posedge clock);
    #1;
  endtask
  // Main sequence.
  initial begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    rdchk(`SCPC_OFF_CONTROL, 32'h18);
    rdchk(`SCPC_OFF_FEEDBACK, 32'h28);
    rdchk(`SCPC_OFF_STAB_TIMER, 0);
    check(32'(pumpCurrent), autoPump(32'h28));
    check(32'(clockStable), 1);
    check(32'(externalFilter), 0);
    apb(1'b0, 12'h3F0, 32'h0, 1'b1);
    wr(`SCPC_OFF_FEEDBACK, 5);
    rdchk(`SCPC_OFF_FEEDBACK, 32'h28);
    // Divider ends and random values; automatic pump follows the divider.
    for (int i = 0; i < 6; i++) begin
      n = (i == 0) ? 6 : (i == 1) ? 255 : 6 + {$random(seed)} % 250;
      wr(`SCPC_OFF_FEEDBACK, n);
      check(32'(feedbackDivide), n);
      check(32'(pumpCurrent), autoPump(n));
    end
    // Manual pump steps and the external filter bit.
    for (int i = 0; i < 4; i++) begin
      n = {$random(seed)} % 8;
      wr(`SCPC_OFF_CONTROL, 32'h40 | (n << 3) | ((i & 1) << 7));
      check(32'(pumpCurrent), n);
      check(32'(externalFilter), i & 1);
    end
    // Every path code; code 3 leaves the crystal path in place.
    for (int i = 0; i < 4; i++) begin
      wr(`SCPC_OFF_SETUP, pathSet[i]);
      check(32'({directPathSel, multiplierEnable, crystalAmpEnable}),
            pathExp[i]);
    end
    // Low-rate path with doubler and every predivider code.
    for (int i = 0; i < 4; i++) begin
      wr(`SCPC_OFF_SETUP, 32'h11 | (i << 2));
      check(32'(predivideRatio), 32'h1 << i);
      check(32'(doublerEnable), 1);
    end
    wr(`SCPC_OFF_IRQ_STATUS, 7);
    wr(`SCPC_OFF_IRQ_MASK, 1);
    // Short runs broken by a miss never lock; a full run does.
    for (int c = 0; c < 4; c++) begin
      wr(`SCPC_OFF_CONTROL, c);
      n = lockCount(c);
      runFor(n - 1, n + 2);
      runFor(n - 1, n + 2);
      check(32'(multiplierLocked), 0);
      check(32'(irq), 0);
      runFor(n + 12, n + 6);
      check(32'(multiplierLocked), 1);
      check(32'(irq), 1);
      repeat (12) @(posedge clock);
      #1 check(32'(multiplierLocked), 0);
      apb(1'b0, `SCPC_OFF_IRQ_STATUS, 32'h0, 1'b0);
      check(rd & 32'h3, 32'h3);
      wr(`SCPC_OFF_IRQ_STATUS, 3);
      check(32'(irq), 0);
    end
    // A nonzero timer holds the clock unstable until it has run out.
    wr(`SCPC_OFF_STAB_TIMER, 1);
    rdchk(`SCPC_OFF_STAB_TIMER, 1);
    check(32'(clockStable), 0);
    wr(`SCPC_OFF_SETUP, 32'h20);
    repeat (4) @(posedge clock);
    #1 check(32'(clockStable), 0);
    // Detector off with the timer at zero keeps the clock stable.
    wr(`SCPC_OFF_STAB_TIMER, 0);
    wr(`SCPC_OFF_CONTROL, 4);
    rdchk(`SCPC_OFF_CONTROL, 4);
    check(32'(multiplierLocked), 0);
    check(32'(clockStable), 1);
    reportAndStop;
  end
endmodule

// File: rtl/scpc_control.sv
// System clock multiplier control: path select, divider, lock and timer.
// ==========================================================================
// Functional notes
// - The sampling clock comes from the input pins through one of three paths.
// - Low-rate and crystal paths always go through the multiplier.
// - The direct path into the multiplier has a predivider of 1, 2, 4 or 8.
// - The feedback divider accepts 6 through 255 only.
// - Control bit 2 set disables the lock detector; clear (default) enables it.
// - The comparator runs at oscillator over feedback divider, one sample each.
// - Consecutive aligned samples are counted, a miss restarts the count.
// - A two-bit field selects 128, 256, 512 or 1024 samples, default 128.
// - In automatic pump mode the current follows the feedback divider.
// - In manual mode a three-bit field sets the current, default fourth step.
// - The external filter bit bypasses the internal loop filter.
// - A zero stability timer times out at once, else it runs in milliseconds.
`timescale 1ns/10ps
`include "scpc_map.svh"
module scpc_control
  import scpc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        phaseAligned,
  output logic             directPathSel,
  output logic             multiplierEnable,
  output logic             crystalAmpEnable,
  output logic             doublerEnable,
  output logic      [3:0]  predivideRatio,
  output logic      [7:0]  feedbackDivide,
  output logic      [2:0]  pumpCurrent,
  output logic             externalFilter,
  output logic             multiplierLocked,
  output logic             clockStable,
  output logic             irq
);
  // ========================================================================
  // State
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [19:0] timerMs;
    scpc_path_type path;
    logic [1:0]  predivSel;
    logic        doubler;
    logic        pllDisable;
    logic [7:0]  fbDiv;
    logic [10:0] alignCount;
    logic        locked;
    scpc_timer_type tmr;
    logic [19:0] msLeft;
    logic [17:0] tick;
    logic [2:0]  irqStat;
    logic [2:0]  irqMask;
    logic [31:0] rdata;
  } scpc_state_type;

  scpc_state_type st_reg;
  scpc_state_type st_next;

  logic        wr;
  logic        rd;
  logic        mapped;
  logic        pllOff;
  logic [10:0] threshold;
  logic        startOk;
  logic        stableNow;
  logic [2:0]  events;
  logic [31:0] rv;

  // Writes land at the access edge; read data is latched at the setup edge
  // so that it already stands while the access phase is sampled.
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  // Threshold doubles per code step from the base count.
  assign threshold = 11'(`SCPC_LOCK_BASE << st_reg.ctrl[1:0]);
  // The multiplier is off only on the direct path with the PLL disabled.
  assign pllOff = (st_reg.path == PATH_DIRECT) && st_reg.pllDisable;
  // Timer starts on lock, or at once when the multiplier is off.
  assign startOk = pllOff || st_reg.locked;
  assign stableNow = (st_reg.timerMs == 20'h00000) || (st_reg.tmr == TMR_DONE);

  // Read decode of the register map.
  always_comb begin
    mapped = 1'b1;
    rv = 32'h0000_0000;
    unique case (paddr)
      `SCPC_OFF_CONTROL:    rv = {24'h000000, st_reg.ctrl};
      `SCPC_OFF_STAB_TIMER: rv = {12'h000, st_reg.timerMs};
      `SCPC_OFF_SETUP:      rv = {26'h0, st_reg.pllDisable, st_reg.doubler,
                                  st_reg.predivSel, 2'(st_reg.path)};
      `SCPC_OFF_FEEDBACK:   rv = {24'h000000, st_reg.fbDiv};
      `SCPC_OFF_STATUS:     rv = {30'h0, stableNow, st_reg.locked};
      `SCPC_OFF_IRQ_STATUS: rv = {29'h0, st_reg.irqStat};
      `SCPC_OFF_IRQ_MASK:   rv = {29'h0, st_reg.irqMask};
      default:              mapped = 1'b0;
    endcase
  end

  // Next-state logic for registers, lock detector and stability timer.
  always_comb begin
    st_next = st_reg;
    events = 3'h0;
    if (rd) begin
      st_next.rdata = rv;
    end
    if (wr) begin
      unique case (paddr)
        `SCPC_OFF_CONTROL:    st_next.ctrl = pwdata[7:0];
        `SCPC_OFF_STAB_TIMER: st_next.timerMs = pwdata[19:0];
        `SCPC_OFF_SETUP: begin
          if (pwdata[1:0] != 2'h3) begin
            st_next.path = scpc_path_type'(pwdata[1:0]);
          end
          st_next.predivSel = pwdata[3:2];
          st_next.doubler = pwdata[4];
          st_next.pllDisable = pwdata[5];
        end
        `SCPC_OFF_FEEDBACK: begin
          if (pwdata[7:0] >= `SCPC_FB_MIN) begin
            st_next.fbDiv = pwdata[7:0];
          end
        end
        `SCPC_OFF_IRQ_MASK:   st_next.irqMask = pwdata[2:0];
        default: ;
      endcase
    end
    // Unless the detector or the multiplier is off, each sample from the comparator updates the aligned run length.
    if (st_reg.ctrl[`SCPC_BIT_LOCK_OFF] || pllOff) begin
      st_next.alignCount = 11'h000;
      st_next.locked = 1'b0;
    end else if (!phaseAligned) begin
      st_next.alignCount = 11'h000;
      st_next.locked = 1'b0;
    end else if (st_reg.alignCount + 11'h001 >= threshold) begin
      st_next.alignCount = threshold;
      st_next.locked = 1'b1;
    end else begin
      st_next.alignCount = st_reg.alignCount + 11'h001;
    end
    // Stability timer counts whole milliseconds after its start.
    unique case (st_reg.tmr)
      TMR_IDLE: begin
        st_next.tick = 18'h0;
        st_next.msLeft = st_reg.timerMs;
        if (startOk && st_reg.timerMs != 20'h0) begin
          st_next.tmr = TMR_RUN;
        end
      end
      TMR_RUN: begin
        if (!startOk) begin
          st_next.tmr = TMR_IDLE;
        end else if (st_reg.tick == 18'(`SCPC_MS_CYCLES - 1)) begin
          st_next.tick = 18'h0;
          if (st_reg.msLeft <= 20'h1) begin
            st_next.tmr = TMR_DONE;
          end else begin
            st_next.msLeft = st_reg.msLeft - 20'h1;
          end
        end else begin
          st_next.tick = st_reg.tick + 18'h1;
        end
      end
      TMR_DONE: begin
        if (!startOk) begin
          st_next.tmr = TMR_IDLE;
        end
      end
      default: st_next.tmr = TMR_IDLE;
    endcase
    if (wr && paddr == `SCPC_OFF_STAB_TIMER) begin
      st_next.tmr = TMR_IDLE;
    end
    // Events: lock gained, lock lost, clock became stable.
    events[0] = st_next.locked && !st_reg.locked;
    events[1] = !st_next.locked && st_reg.locked;
    events[2] = (st_next.tmr == TMR_DONE) && (st_reg.tmr != TMR_DONE);
    // Write-one clears; a new event in the same cycle wins.
    if (wr && paddr == `SCPC_OFF_IRQ_STATUS) begin
      st_next.irqStat = st_reg.irqStat & ~pwdata[2:0];
    end
    st_next.irqStat = st_next.irqStat | events;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '{ctrl: `SCPC_CTRL_RESET, path: PATH_DIRECT,
                  fbDiv: `SCPC_FB_RESET, tmr: TMR_IDLE, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ========================================================================
  // Outputs
  // Bus handshake: zero wait states, error on an unmapped address.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = st_reg.rdata;
  // Path selection outputs.
  assign directPathSel = (st_reg.path == PATH_DIRECT) && st_reg.pllDisable;
  // Low-rate and crystal force the multiplier on.
  assign multiplierEnable = (st_reg.path != PATH_DIRECT)
                            || !st_reg.pllDisable;
  assign crystalAmpEnable = (st_reg.path == PATH_CRYSTAL);
  assign doublerEnable = (st_reg.path == PATH_LOW_RATE) && st_reg.doubler;
  // Divider settings seen by the multiplier.
  assign predivideRatio = 4'(4'h1 << st_reg.predivSel);
  assign feedbackDivide = st_reg.fbDiv;
  // Automatic pump current scales with the feedback divider.
  assign pumpCurrent = st_reg.ctrl[`SCPC_BIT_CP_MANUAL]
                       ? st_reg.ctrl[`SCPC_CP_CUR_MSB:`SCPC_CP_CUR_LSB]
                       : st_reg.fbDiv[7:5];
  assign externalFilter = st_reg.ctrl[`SCPC_BIT_EXT_FILTER];
  // Lock, stability and interrupt status.
  assign multiplierLocked = st_reg.locked;
  assign clockStable = stableNow;
  assign irq = |(st_reg.irqStat & st_reg.irqMask);

  // ========================================================================
  // Checks
  a_lock_needs_run: assert property (
    @(posedge clock) disable iff (!resetn)
    !st_reg.locked && st_next.locked |-> phaseAligned)
    else $error("lock without aligned sample");
  a_miss_clears: assert property (
    @(posedge clock) disable iff (!resetn)
    !phaseAligned |=> st_reg.alignCount == 11'h000)
    else $error("miss did not restart count");
  a_lock_drop: assert property (
    @(posedge clock) disable iff (!resetn)
    multiplierLocked && !phaseAligned |=> !multiplierLocked)
    else $error("lock kept after a miss");
  a_detector_off: assert property (
    @(posedge clock) disable iff (!resetn)
    st_reg.ctrl[`SCPC_BIT_LOCK_OFF] |=> !multiplierLocked)
    else $error("lock with detector off");
  a_pll_off_unlock: assert property (
    @(posedge clock) disable iff (!resetn)
    pllOff |=> !multiplierLocked)
    else $error("lock with multiplier off");
  a_fb_range: assert property (
    @(posedge clock) disable iff (!resetn)
    feedbackDivide >= `SCPC_FB_MIN)
    else $error("feedback divider below minimum");
  a_fb_refused: assert property (
    @(posedge clock) disable iff (!resetn)
    wr && paddr == `SCPC_OFF_FEEDBACK && pwdata[7:0] < `SCPC_FB_MIN
    |=> $stable(feedbackDivide))
    else $error("small feedback divider accepted");
  a_zero_timer: assert property (
    @(posedge clock) disable iff (!resetn)
    st_reg.timerMs == 20'h0 |-> clockStable)
    else $error("zero timer not stable");
  a_stable_wait: assert property (
    @(posedge clock) disable iff (!resetn)
    st_reg.tmr == TMR_RUN |-> !clockStable)
    else $error("stable while timer runs");
  a_timer_rearm: assert property (
    @(posedge clock) disable iff (!resetn)
    wr && paddr == `SCPC_OFF_STAB_TIMER |=> st_reg.tmr == TMR_IDLE)
    else $error("timer not restarted by write");
  a_auto_pump: assert property (
    @(posedge clock) disable iff (!resetn)
    !st_reg.ctrl[`SCPC_BIT_CP_MANUAL] |-> pumpCurrent == feedbackDivide[7:5])
    else $error("auto pump current mismatch");
  a_manual_pump: assert property (
    @(posedge clock) disable iff (!resetn)
    st_reg.ctrl[`SCPC_BIT_CP_MANUAL]
    |-> pumpCurrent == st_reg.ctrl[`SCPC_CP_CUR_MSB:`SCPC_CP_CUR_LSB])
    else $error("manual pump current mismatch");
  a_multi_path: assert property (
    @(posedge clock) disable iff (!resetn)
    st_reg.path != PATH_DIRECT |-> multiplierEnable && !directPathSel)
    else $error("synth path bypassed multiplier");
  a_crystal_multi: assert property (
    @(posedge clock) disable iff (!resetn)
    crystalAmpEnable |-> multiplierEnable)
    else $error("crystal path without multiplier");
  a_direct_excl: assert property (
    @(posedge clock) disable iff (!resetn)
    directPathSel |-> !multiplierEnable && !crystalAmpEnable)
    else $error("direct path not exclusive");
  a_path_hold: assert property (
    @(posedge clock) disable iff (!resetn)
    wr && paddr == `SCPC_OFF_SETUP && pwdata[1:0] == 2'h3
    |=> $stable(st_reg.path))
    else $error("illegal path code accepted");
  a_prediv_set: assert property (
    @(posedge clock) disable iff (!resetn)
    $onehot(predivideRatio))
    else $error("illegal predivide ratio");
  a_ext_filter: assert property (
    @(posedge clock) disable iff (!resetn)
    externalFilter == st_reg.ctrl[`SCPC_BIT_EXT_FILTER])
    else $error("filter select mismatch");
  a_set_wins: assert property (
    @(posedge clock) disable iff (!resetn)
    $rose(multiplierLocked) |-> st_reg.irqStat[0])
    else $error("lock gained flag missing");
  a_w1c_clear: assert property (
    @(posedge clock) disable iff (!resetn)
    wr && paddr == `SCPC_OFF_IRQ_STATUS && pwdata[1] && !events[1]
    |=> !st_reg.irqStat[1])
    else $error("lock lost flag not cleared");
endmodule

// File: rtl/scpc_map.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef SCPC_MAP_SVH
`define SCPC_MAP_SVH
`define SCPC_IDX_CONTROL     12'h100
`define SCPC_IDX_STAB_TIMER  12'h106
`define SCPC_IDX_SETUP       12'h110
`define SCPC_IDX_FEEDBACK    12'h114
`define SCPC_IDX_STATUS      12'h118
`define SCPC_IDX_IRQ_STATUS  12'h11C
`define SCPC_IDX_IRQ_MASK    12'h120
`define SCPC_OFF_CONTROL     (`SCPC_IDX_CONTROL << 2)
`define SCPC_OFF_STAB_TIMER  (`SCPC_IDX_STAB_TIMER << 2)
`define SCPC_OFF_SETUP       (`SCPC_IDX_SETUP << 2)
`define SCPC_OFF_FEEDBACK    (`SCPC_IDX_FEEDBACK << 2)
`define SCPC_OFF_STATUS      (`SCPC_IDX_STATUS << 2)
`define SCPC_OFF_IRQ_STATUS  (`SCPC_IDX_IRQ_STATUS << 2)
`define SCPC_OFF_IRQ_MASK    (`SCPC_IDX_IRQ_MASK << 2)
`define SCPC_CTRL_RESET      8'h18
`define SCPC_BIT_LOCK_OFF    2
`define SCPC_BIT_CP_MANUAL   6
`define SCPC_BIT_EXT_FILTER  7
`define SCPC_CP_CUR_LSB      3
`define SCPC_CP_CUR_MSB      5
`define SCPC_FB_MIN          8'h06
`define SCPC_FB_MAX          8'hFF
`define SCPC_FB_RESET        8'h28
`define SCPC_LOCK_BASE       11'h080
`define SCPC_TIMER_WIDTH     20
`define SCPC_MS_NS           1000000
`define SCPC_CLK_NS          4
`define SCPC_MS_CYCLES       (`SCPC_MS_NS / `SCPC_CLK_NS)
`define SCPC_IRQ_BITS        3
`endif

// File: rtl/scpc_pkg.sv
// Types for the system clock multiplier control block.
package scpc_pkg;
  typedef enum logic [1:0] {
    PATH_DIRECT, PATH_LOW_RATE, PATH_CRYSTAL
  } scpc_path_type;
  typedef enum logic [1:0] {
    TMR_IDLE, TMR_RUN, TMR_DONE
  } scpc_timer_type;
endpackage
